// [pkg/rsq_pkg.sv]
/*
 * Shared constants of the system reset sequencer: stage delays, synchroniser
 * layout and reset values.
 * Assumes it is compiled before every file of the sequencer.
 */
package rsq_pkg;

    // ==========================================================================
    // Release delays of the reset stages.
    // ==========================================================================
    // Counted in oscillator clock cycles.
    localparam int EXT_POR_OSC_CYCLES = 64;
    localparam int CLKGEN_OSC_CYCLES  = 32;
    // Counted in divided system clock cycles.
    localparam int PERIPH_SYS_CYCLES  = 32;
    localparam int CORE_SYS_CYCLES    = 32;
    // Longest stretch of the clock generator reset after a power-on reset.
    localparam int MAX_STRETCH_OSC_CYCLES = EXT_POR_OSC_CYCLES + CLKGEN_OSC_CYCLES;

    // ==========================================================================
    // Pin synchroniser layout.
    // ==========================================================================
    localparam int SYNC_WIDTH    = 4;
    localparam int SYNC_POR_N    = 0;
    localparam int SYNC_EXT_N    = 1;
    localparam int SYNC_OSC      = 2;
    localparam int SYNC_DCLK     = 3;
    // Reset sources read as asserted and clocks as low until sampled.
    localparam logic [3:0] SYNC_RESET_VALUE = 4'h0;

    // ==========================================================================
    // Reset values of outputs and helper counters.
    // ==========================================================================
    localparam logic       RESET_ASSERTED  = 1'h1;
    localparam logic       SYSCLK_RESET    = 1'h0;
    localparam int         MON_WIDTH       = 8;
    localparam logic [7:0] MON_SATURATE    = 8'hFF;

endpackage

// [src/rsq_release_stage.sv]
/*
 * One stage of the reset chain: asserted on the next clock while its hold input is
 * high, released once a given number of ticks has passed and a release edge
 * arrives.
 * Assumes tick and release inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps

module rsq_release_stage #(
    parameter int DELAY = 32
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic sys_rst,
    // Control.
    input  wire logic hold,
    input  wire logic count_tick,
    input  wire logic release_ok,
    // Stage output, active high.
    output logic      reset_out
);

    localparam int CW = $clog2(DELAY + 1);
    localparam logic [CW-1:0] DONE = CW'(DELAY);

    logic [CW-1:0] count_reg;

    // ==========================================================================
    // Tick counter.
    // ==========================================================================
    // The counter saturates so that a late release edge still finds it done.
    always_ff @(posedge clock) begin
        if (sys_rst || hold) begin
            count_reg <= '0;
        end else if (count_tick && count_reg != DONE) begin
            count_reg <= count_reg + CW'(1);
        end
    end

    // ==========================================================================
    // Output register.
    // ==========================================================================
    always_ff @(posedge clock) begin
        if (sys_rst || hold) begin
            reset_out <= rsq_pkg::RESET_ASSERTED;
        end else if (count_reg == DONE && release_ok) begin
            reset_out <= 1'h0;
        end
    end

    property p_hold_asserts;
        @(posedge clock) disable iff (sys_rst)
        hold |=> reset_out && count_reg == '0;
    endproperty
    a_hold_asserts: assert property (p_hold_asserts) else $error("stage not asserted after hold");

endmodule

// [src/rsq_reset_sequencer.sv]
/*
 * System reset sequencer: merges power-on, external pin, software and
 * watchdog reset sources into staged internal resets and divides the
 * double-rate system clock by two.
 * Assumes one fast sampling clock; the oscillator and double-rate system
 * clocks arrive as slower levels and are sampled as ordinary pins.
 */
//
// Overview of operation
// - Four sources: pin and power-on asynchronous, software and watchdog synchronous.
// - A write of the integration control register raises a software reset.
// - The test port reset follows power-on reset only.
// - Extended power-on reset holds 64 oscillator cycles after power-on release.
// - Clock generator reset asserted by any source, released 32 oscillator cycles later.
// - Peripheral reset released 32 system cycles after clock generator reset.
// - Core reset released 32 system cycles after peripheral reset.
// - Extension counters count oscillator clock edges.
// - Oscillator clock keeps running, also during reset.
// - Combined reset is the AND of all active-low sources.
// - Clock generator reset stretched up to 96 oscillator cycles after power-on.
// - Resets assert at any time; only peripheral and core resets release on a system clock edge.
// - Clock generator reset releases on an oscillator falling edge.
// - Peripheral and core resets release on a system clock falling edge.
// - System clock is the double-rate clock divided by two.
// - The block raises no interrupt.
`timescale 1ns/1ps

module rsq_reset_sequencer #(
    parameter int EXT_POR_CYCLES = rsq_pkg::EXT_POR_OSC_CYCLES,
    parameter int CLKGEN_CYCLES  = rsq_pkg::CLKGEN_OSC_CYCLES,
    parameter int PERIPH_CYCLES  = rsq_pkg::PERIPH_SYS_CYCLES,
    parameter int CORE_CYCLES    = rsq_pkg::CORE_SYS_CYCLES
) (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic sys_rst,
    // Asynchronous reset sources, active low.
    input  wire logic power_on_reset_n,
    input  wire logic external_reset_n,
    // Synchronous reset sources, one-cycle pulses.
    input  wire logic integration_control_write,
    input  wire logic watchdog_reset_source_req,
    // Clock inputs sampled as levels.
    input  wire logic oscillator_clock,
    input  wire logic double_rate_system_clock,
    // Divided clock.
    output logic      system_clock,
    // Staged resets, active high.
    output logic      tap_reset,
    output logic      extended_por_reset,
    output logic      clock_generator_reset,
    output logic      peripheral_reset,
    output logic      core_reset
);

    // ==========================================================================
    // Pin synchronisers.
    // ==========================================================================
    logic [rsq_pkg::SYNC_WIDTH-1:0] pin_raw;
    logic [rsq_pkg::SYNC_WIDTH-1:0] sync_meta_reg;
    logic [rsq_pkg::SYNC_WIDTH-1:0] sync_reg;

    assign pin_raw[rsq_pkg::SYNC_POR_N] = power_on_reset_n;
    assign pin_raw[rsq_pkg::SYNC_EXT_N] = external_reset_n;
    assign pin_raw[rsq_pkg::SYNC_OSC]   = oscillator_clock;
    assign pin_raw[rsq_pkg::SYNC_DCLK]  = double_rate_system_clock;

    // Pin and power-on sources are asynchronous, so they pass two flops.
    for (genvar i = 0; i < rsq_pkg::SYNC_WIDTH; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                sync_meta_reg[i] <= rsq_pkg::SYNC_RESET_VALUE[i];
                sync_reg[i]      <= rsq_pkg::SYNC_RESET_VALUE[i];
            end else begin
                sync_meta_reg[i] <= pin_raw[i];
                sync_reg[i]      <= sync_meta_reg[i];
            end
        end
    end

    logic por_n_s;
    logic ext_n_s;
    logic osc_s;
    logic dclk_s;

    assign por_n_s = sync_reg[rsq_pkg::SYNC_POR_N];
    assign ext_n_s = sync_reg[rsq_pkg::SYNC_EXT_N];
    assign osc_s   = sync_reg[rsq_pkg::SYNC_OSC];
    assign dclk_s  = sync_reg[rsq_pkg::SYNC_DCLK];

    // ==========================================================================
    // Clock edge detection.
    // ==========================================================================
    logic osc_prev_reg;
    logic dclk_prev_reg;
    logic osc_rise;
    logic osc_fall;
    logic dclk_rise;

    localparam int SETTLE_STAGES = 3;

    logic [SETTLE_STAGES-1:0] settle_reg;
    logic                     edges_ok;

    // After a reset the synchronisers and the previous-level flops read low
    // whatever the pins do, so edges are ignored until both hold real samples;
    // otherwise a high pin would count as a false edge.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            settle_reg <= '0;
        end else begin
            settle_reg <= {settle_reg[SETTLE_STAGES-2:0], 1'h1};
        end
    end

    assign edges_ok = settle_reg[SETTLE_STAGES-1];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_prev_reg  <= rsq_pkg::SYNC_RESET_VALUE[rsq_pkg::SYNC_OSC];
            dclk_prev_reg <= rsq_pkg::SYNC_RESET_VALUE[rsq_pkg::SYNC_DCLK];
        end else begin
            osc_prev_reg  <= osc_s;
            dclk_prev_reg <= dclk_s;
        end
    end

    // The oscillator is never gated here, so its edges keep arriving during reset.
    assign osc_rise  = edges_ok && osc_s && !osc_prev_reg;
    assign osc_fall  = edges_ok && !osc_s && osc_prev_reg;
    assign dclk_rise = edges_ok && dclk_s && !dclk_prev_reg;

    // ==========================================================================
    // System clock divider.
    // ==========================================================================
    logic sys_rise;
    logic sys_fall;

    // Each rising edge of the double-rate clock toggles the divided clock.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            system_clock <= rsq_pkg::SYSCLK_RESET;
        end else if (dclk_rise) begin
            system_clock <= !system_clock;
        end
    end

    assign sys_rise = dclk_rise && !system_clock;
    assign sys_fall = dclk_rise && system_clock;

    // ==========================================================================
    // Combined reset.
    // ==========================================================================
    logic combined_n;

    // Software reset is the register write pulse; it joins the same tree.
    // Any low source pulls the combined reset low.
    assign combined_n = por_n_s && ext_n_s && !integration_control_write && !watchdog_reset_source_req;

    // ==========================================================================
    // Test port reset.
    // ==========================================================================
    // Only power-on reset reaches the test port, so a debugger survives the others.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tap_reset <= rsq_pkg::RESET_ASSERTED;
        end else begin
            tap_reset <= !por_n_s;
        end
    end

    // ==========================================================================
    // Reset chain.
    // ==========================================================================
    logic clkgen_hold;
    logic periph_hold;
    logic core_hold;

    // The clock generator reset waits for the extended power-on reset too,
    // which gives 64 plus 32 oscillator cycles after power-on.
    assign clkgen_hold = !combined_n || extended_por_reset;
    assign periph_hold = !combined_n || clock_generator_reset;
    assign core_hold   = !combined_n || peripheral_reset;

    // Extension counters tick on oscillator edges because the system clock
    // may not run yet in this phase.
    rsq_release_stage #(
        .DELAY (EXT_POR_CYCLES)
    ) u_ext_por (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .hold       (!por_n_s),
        .count_tick (osc_rise),
        .release_ok (1'h1),
        .reset_out  (extended_por_reset)
    );

    rsq_release_stage #(
        .DELAY (CLKGEN_CYCLES)
    ) u_clkgen (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .hold       (clkgen_hold),
        .count_tick (osc_rise),
        .release_ok (osc_fall),
        .reset_out  (clock_generator_reset)
    );

    // Release on the divided clock's falling edge keeps it clear of the
    // rising edge on which peripherals sample.
    rsq_release_stage #(
        .DELAY (PERIPH_CYCLES)
    ) u_periph (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .hold       (periph_hold),
        .count_tick (sys_rise),
        .release_ok (sys_fall),
        .reset_out  (peripheral_reset)
    );

    rsq_release_stage #(
        .DELAY (CORE_CYCLES)
    ) u_core (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .hold       (core_hold),
        .count_tick (sys_rise),
        .release_ok (sys_fall),
        .reset_out  (core_reset)
    );

    // There is no interrupt output; events show only on the reset lines.

    // ==========================================================================
    // Checking helpers.
    // ==========================================================================
    // Each counter measures edges since the cause of a release went away.
    logic [rsq_pkg::MON_WIDTH-1:0] mon_por_reg;
    logic [rsq_pkg::MON_WIDTH-1:0] mon_clkgen_reg;
    logic [rsq_pkg::MON_WIDTH-1:0] mon_periph_reg;
    logic [rsq_pkg::MON_WIDTH-1:0] mon_core_reg;

    always_ff @(posedge clock) begin
        if (sys_rst || !por_n_s) begin
            mon_por_reg <= '0;
        end else if (osc_rise && mon_por_reg != rsq_pkg::MON_SATURATE) begin
            mon_por_reg <= mon_por_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || clkgen_hold) begin
            mon_clkgen_reg <= '0;
        end else if (osc_rise && mon_clkgen_reg != rsq_pkg::MON_SATURATE) begin
            mon_clkgen_reg <= mon_clkgen_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || periph_hold) begin
            mon_periph_reg <= '0;
        end else if (sys_rise && mon_periph_reg != rsq_pkg::MON_SATURATE) begin
            mon_periph_reg <= mon_periph_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || core_hold) begin
            mon_core_reg <= '0;
        end else if (sys_rise && mon_core_reg != rsq_pkg::MON_SATURATE) begin
            mon_core_reg <= mon_core_reg + 8'h01;
        end
    end

    // ==========================================================================
    // Assertions.
    // ==========================================================================
    property p_tap_por_only;
        @(posedge clock) disable iff (sys_rst)
        $past(por_n_s) && por_n_s |-> !tap_reset;
    endproperty
    a_tap_por_only: assert property (p_tap_por_only) else $error("test port reset without power-on");

    property p_ext_por_source;
        @(posedge clock) disable iff (sys_rst)
        $rose(extended_por_reset) |-> !$past(por_n_s);
    endproperty
    a_ext_por_source: assert property (p_ext_por_source) else $error("extended reset from wrong source");

    property p_ext_por_len;
        @(posedge clock) disable iff (sys_rst)
        $fell(extended_por_reset) |-> $past(mon_por_reg) == 8'(EXT_POR_CYCLES);
    endproperty
    a_ext_por_len: assert property (p_ext_por_len) else $error("extended reset length wrong");

    property p_clkgen_len;
        @(posedge clock) disable iff (sys_rst)
        $fell(clock_generator_reset) |-> $past(mon_clkgen_reg) == 8'(CLKGEN_CYCLES) && $past(osc_fall);
    endproperty
    a_clkgen_len: assert property (p_clkgen_len) else $error("clock generator release wrong");

    property p_any_source;
        @(posedge clock) disable iff (sys_rst)
        !combined_n |=> clock_generator_reset && peripheral_reset && core_reset;
    endproperty
    a_any_source: assert property (p_any_source) else $error("source did not assert resets");

    property p_sw_source;
        @(posedge clock) disable iff (sys_rst)
        integration_control_write |=> clock_generator_reset ##1 clock_generator_reset;
    endproperty
    a_sw_source: assert property (p_sw_source) else $error("software reset not applied");

    property p_periph_len;
        @(posedge clock) disable iff (sys_rst)
        $fell(peripheral_reset) |-> $past(mon_periph_reg) == 8'(PERIPH_CYCLES) && $past(sys_fall);
    endproperty
    a_periph_len: assert property (p_periph_len) else $error("peripheral release wrong");

    property p_core_len;
        @(posedge clock) disable iff (sys_rst)
        $fell(core_reset) |-> $past(mon_core_reg) == 8'(CORE_CYCLES) && $past(sys_fall) && !peripheral_reset;
    endproperty
    a_core_len: assert property (p_core_len) else $error("core release wrong");

    property p_divider;
        @(posedge clock) disable iff (sys_rst)
        dclk_rise |=> system_clock != $past(system_clock);
    endproperty
    a_divider: assert property (p_divider) else $error("divided clock did not toggle");

    property p_divider_hold;
        @(posedge clock) disable iff (sys_rst)
        !dclk_rise |=> $stable(system_clock);
    endproperty
    a_divider_hold: assert property (p_divider_hold) else $error("divided clock toggled early");

    property p_order;
        @(posedge clock) disable iff (sys_rst)
        !core_reset |-> !peripheral_reset && !clock_generator_reset && !extended_por_reset;
    endproperty
    a_order: assert property (p_order) else $error("reset release order broken");

    property p_por_asserts;
        @(posedge clock) disable iff (sys_rst)
        !por_n_s |=> tap_reset && extended_por_reset;
    endproperty
    a_por_asserts: assert property (p_por_asserts) else $error("power-on did not assert its resets");

endmodule

// [bench/rsq_source_model.sv]
/*
 * Partner model: power-on detector, external reset pin driver and the free
 * running oscillator and double-rate system clocks.
 * Assumes the bench changes the request inputs shortly after a rising edge.
 */
`timescale 1ns/1ps

module rsq_source_model (
    // Sampling clock.
    input  wire logic clock,
    // Requests from the bench, active low.
    input  wire logic por_req_n,
    input  wire logic ext_req_n,
    // Pins towards the sequencer.
    output logic      power_on_reset_n,
    output logic      external_reset_n,
    output logic      oscillator_clock,
    output logic      double_rate_system_clock
);
    int osc_cnt  = 0;
    int dclk_cnt = 0;

    initial begin
        power_on_reset_n         = 1'h0;
        external_reset_n         = 1'h1;
        oscillator_clock         = 1'h0;
        double_rate_system_clock = 1'h0;
    end

    // ==========================================================================
    // Clocks and pins.
    // ==========================================================================
    // The oscillator never stops, also while any reset is held; pins only move
    // mid-phase so a source edge never lands on an oscillator edge.
    always @(posedge clock) begin
        #1;
        osc_cnt  = (osc_cnt + 1) % 5;
        dclk_cnt = (dclk_cnt + 1) % 4;
        if (osc_cnt == 0) begin
            oscillator_clock = ~oscillator_clock;
        end
        if (dclk_cnt == 0) begin
            double_rate_system_clock = ~double_rate_system_clock;
        end
        if (osc_cnt == 2) begin
            power_on_reset_n = por_req_n;
            external_reset_n = ext_req_n;
        end
    end
endmodule

// [bench/tb_top.sv]
/*
 * Self-checking bench of the reset sequencer with default stage counts.
 * Assumes the partner model supplies pins and clocks, five and four samples
 * a half period.
 */
`timescale 1ns/1ps

module tb_top;
    logic clock                     = 1'h0;
    logic sys_rst                   = 1'h1;
    logic por_req_n                 = 1'h0;
    logic ext_req_n                 = 1'h1;
    logic integration_control_write = 1'h0;
    logic watchdog_reset_source_req = 1'h0;
    logic power_on_reset_n;
    logic external_reset_n;
    logic oscillator_clock;
    logic double_rate_system_clock;
    logic system_clock;
    logic tap_reset;
    logic extended_por_reset;
    logic clock_generator_reset;
    logic peripheral_reset;
    logic core_reset;
    int   n_errors                  = 0;
    int   checked                   = 0;
    int   cycles                    = 0;

    always #5 clock = ~clock;

    rsq_source_model u_model (
        .clock                    (clock),
        .por_req_n                (por_req_n),
        .ext_req_n                (ext_req_n),
        .power_on_reset_n         (power_on_reset_n),
        .external_reset_n         (external_reset_n),
        .oscillator_clock         (oscillator_clock),
        .double_rate_system_clock (double_rate_system_clock)
    );

    rsq_reset_sequencer DUT (
        .clock                     (clock),
        .sys_rst                   (sys_rst),
        .power_on_reset_n          (power_on_reset_n),
        .external_reset_n          (external_reset_n),
        .integration_control_write (integration_control_write),
        .watchdog_reset_source_req (watchdog_reset_source_req),
        .oscillator_clock          (oscillator_clock),
        .double_rate_system_clock  (double_rate_system_clock),
        .system_clock              (system_clock),
        .tap_reset                 (tap_reset),
        .extended_por_reset        (extended_por_reset),
        .clock_generator_reset     (clock_generator_reset),
        .peripheral_reset          (peripheral_reset),
        .core_reset                (core_reset)
    );

    // ==========================================================================
    // Compare and report.
    // ==========================================================================
    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        checked++;
        if (got != exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang in any wait below ends here instead of running forever.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            close_out();
        end
    end

    // ==========================================================================
    // Helpers.
    // ==========================================================================
    function automatic logic pick(input int s);
        case (s)
            0: return extended_por_reset;
            1: return clock_generator_reset;
            2: return peripheral_reset;
            default: return core_reset;
        endcase
    endfunction

    // Counts rises of the oscillator (r=0) or system clock (r=1) until stage s
    // releases, then checks the count and the reference level at release.
    task automatic meas(input int s, input int r, input int exp, input logic lvl);
        int   n;
        logic prev;
        logic cur;
        n    = 0;
        prev = r ? system_clock : oscillator_clock;
        cur  = prev;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            #2;
            cur = r ? system_clock : oscillator_clock;
            if (cur && !prev) n++;
            if (pick(s) === 1'h0) break;
            prev = cur;
        end
        check_count(n, exp);
        check_bit(cur, lvl);
        if (r) check_bit(prev, 1'h1);
    endtask

    task automatic chain(input bit with_por);
        if (with_por) meas(0, 0, 64, 1'h1);
        meas(1, 0, 32, 1'h0);
        meas(2, 1, 32, 1'h0);
        meas(3, 1, 32, 1'h0);
    endtask

    task automatic chk_all(input logic tap, input logic ext_por);
        check_bit(clock_generator_reset, 1'h1);
        check_bit(peripheral_reset, 1'h1);
        check_bit(core_reset, 1'h1);
        check_bit(tap_reset, tap);
        check_bit(extended_por_reset, ext_por);
    endtask

    // ==========================================================================
    // Scenarios.
    // ==========================================================================
    task automatic t_power_on();
        repeat (20) @(posedge clock);
        #2;
        chk_all(1'h1, 1'h1);
        por_req_n = 1'h1;
        @(posedge power_on_reset_n);
        chain(1'b1);
        check_bit(tap_reset, 1'h0);
        $display("test power_on done");
    endtask

    task automatic t_sys_reset();
        @(negedge oscillator_clock);
        sys_rst = 1'h1;
        @(posedge clock);
        #2;
        chk_all(1'h1, 1'h1);
        check_bit(system_clock, 1'h0);
        repeat (2) @(posedge clock);
        @(negedge oscillator_clock);
        sys_rst = 1'h0;
        chain(1'b1);
        $display("test sys_reset done");
    endtask

    task automatic t_external();
        ext_req_n = 1'h0;
        @(negedge external_reset_n);
        repeat (4) @(posedge clock);
        #2;
        chk_all(1'h0, 1'h0);
        repeat (30) @(posedge clock);
        #1;
        ext_req_n = 1'h1;
        @(posedge external_reset_n);
        chain(1'b0);
        $display("test external done");
    endtask

    task automatic t_software();
        @(negedge oscillator_clock);
        integration_control_write = 1'h1;
        @(posedge clock);
        #1;
        integration_control_write = 1'h0;
        #1;
        chk_all(1'h0, 1'h0);
        chain(1'b0);
        $display("test software done");
    endtask

    task automatic t_watchdog_restart();
        @(negedge oscillator_clock);
        integration_control_write = 1'h1;
        @(posedge clock);
        #1;
        integration_control_write = 1'h0;
        meas(1, 0, 32, 1'h0);
        repeat (40) @(posedge clock);
        @(negedge oscillator_clock);
        check_bit(peripheral_reset, 1'h1);
        watchdog_reset_source_req = 1'h1;
        @(posedge clock);
        #2;
        chk_all(1'h0, 1'h0);
        @(posedge clock);
        #1;
        watchdog_reset_source_req = 1'h0;
        chain(1'b0);
        $display("test watchdog_restart done");
    endtask

    task automatic t_divide();
        int   n_sys;
        int   n_dclk;
        logic prev_sys;
        logic prev_dclk;
        n_sys  = 0;
        n_dclk = 0;
        @(posedge system_clock);
        #2;
        prev_sys  = system_clock;
        prev_dclk = double_rate_system_clock;
        // A double-rate rise is seen before the toggle it causes, so the
        // divided clock still shows the level left by the previous rise.
        while (n_sys < 10) begin
            @(posedge clock);
            #2;
            if (system_clock && !prev_sys) n_sys++;
            if (double_rate_system_clock && !prev_dclk) begin
                n_dclk++;
                check_bit(system_clock, n_dclk[0]);
            end
            prev_sys  = system_clock;
            prev_dclk = double_rate_system_clock;
        end
        check_count(n_dclk, 20);
        $display("test divide done");
    endtask

    initial begin
        repeat (8) @(posedge clock);
        #1;
        sys_rst = 1'h0;
        t_power_on();
        t_sys_reset();
        t_external();
        t_software();
        t_watchdog_restart();
        t_divide();
        // A second power-on after a full release raises the extended reset again.
        por_req_n = 1'h0;
        t_power_on();
        close_out();
    end
endmodule
